// ===== rtl/glue_pkg.sv
/*
  Shared constants and carrier types of the custom glue logic pair: input source codes,
  filter and pair function codes, control word layouts and reset values.
  Assumes a single clock domain and plain control ports instead of a register bus.
*/
package glue_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_CELLS   = 2;
  localparam int SYNC_STAGES = 2;

  // ==========================================================================
  // Input source select codes, shared by all three lines of both cells
  localparam logic [3:0] SRC_MASKED     = 4'h0;
  localparam logic [3:0] SRC_FEEDBACK   = 4'h1;
  localparam logic [3:0] SRC_LINK       = 4'h2;
  localparam logic [3:0] SRC_EVENT_LINE_ZERO     = 4'h3;
  localparam logic [3:0] SRC_EVENT_LINE_ONE     = 4'h4;
  localparam logic [3:0] SRC_PIN        = 4'h5;
  localparam logic [3:0] SRC_COMPARATOR = 4'h6;
  localparam logic [3:0] SRC_TIMER0     = 4'h7;
  localparam logic [3:0] SRC_TIMER1     = 4'h8;
  localparam logic [3:0] SRC_TIMER2     = 4'h9;
  localparam logic [3:0] SRC_SUBBLOCK   = 4'hA;

  // ==========================================================================
  // Output filter select codes
  localparam logic [1:0] FILT_OFF   = 2'h0;
  localparam logic [1:0] FILT_SYNC  = 2'h1;
  localparam logic [1:0] FILT_MAJOR = 2'h2;

  // ==========================================================================
  // Pair function select codes
  localparam logic [3:0] SEQ_OFF   = 4'h0;
  localparam logic [3:0] SEQ_DFF   = 4'h1;
  localparam logic [3:0] SEQ_JK    = 4'h2;
  localparam logic [3:0] SEQ_LATCH = 4'h3;
  localparam logic [3:0] SEQ_RS    = 4'h4;

  // ==========================================================================
  // Control word layouts
  typedef struct packed {
    logic       rising_pulse_enable;
    logic       cell_clock_source;
    logic [1:0] output_filter_select;
    logic       output_enable;
    logic [1:0] reserved;
    logic       enable;
  } cell_control_a_t;

  typedef struct packed {
    logic [3:0] input_one_source_select;
    logic [3:0] input_zero_source_select;
  } cell_control_b_t;

  typedef struct packed {
    logic       global_enable_wr;
    logic       pair_function_wr;
    logic [1:0] control_a_wr;
    logic [1:0] control_b_wr;
    logic [1:0] control_c_wr;
    logic [1:0] truth_wr;
    logic [7:0] wdata;
  } reg_write_t;

  typedef struct packed {
    logic                  global_enable;
    logic [3:0]            pair_function_select;
    cell_control_a_t [1:0] control_a;
    cell_control_b_t [1:0] control_b;
    logic [1:0][3:0]       input_two_source_select;
    logic [1:0][7:0]       truth;
  } readback_t;

  // ==========================================================================
  // Values after reset
  localparam logic [7:0] CONTROL_A_RESET = 8'h00;
  localparam logic [7:0] CONTROL_B_RESET = 8'h00;
  localparam logic [3:0] CONTROL_C_RESET = 4'h0;
  localparam logic [7:0] TRUTH_RESET     = 8'h00;
  localparam logic [3:0] PAIR_FN_RESET   = 4'h0;

endpackage

// ===== rtl/lookup_cell.sv
/*
  One three-input look-up cell: truth lookup, clock selection, optional two-stage
  synchronizer or majority filter, and rising pulse detector.
  Assumes its input lines are already synchronous to clk_sys.
*/
`timescale 1ns/100ps
module lookup_cell (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      active,
  input  wire glue_pkg::cell_control_a_t ctrl,
  input  wire logic [7:0]                truth,
  input  wire logic [2:0]                lines,
  output logic                           tick,
  output logic                           direct,
  output logic                           result
);
  import glue_pkg::*;

  logic [2:0]             index;
  logic                   staged;
  logic                   clk_line_prev;
  logic                   next_clk_line_prev;
  logic [SYNC_STAGES-1:0] sync_q;
  logic [SYNC_STAGES-1:0] next_sync_q;
  logic [1:0]             taps;
  logic [1:0]             next_taps;
  logic                   filt;
  logic                   next_filt;
  logic                   edge_prev;
  logic                   next_edge_prev;

  // ==========================================================================
  // Lookup and clock selection
  // Line 2 reads as low when it serves as the clock.
  always_comb begin
    index  = {ctrl.cell_clock_source ? 1'b0 : lines[2], lines[1:0]};
    direct = truth[index];
    // The line 2 clock is a rising-edge tick; glitches on it act as extra edges.
    tick   = !ctrl.cell_clock_source || (lines[2] && !clk_line_prev);
  end

  // ==========================================================================
  // Filter and pulse state
  // A disabled cell clears its filter and pulse state on the next edge; the clock line sample keeps following line 2.
  always_comb begin
    next_clk_line_prev = lines[2];
    next_sync_q        = sync_q;
    next_taps          = taps;
    next_filt          = filt;
    next_edge_prev     = edge_prev;
    if (!active) begin
      next_sync_q    = '0;
      next_taps      = '0;
      next_filt      = 1'b0;
      next_edge_prev = 1'b0;
    end else if (tick) begin
      next_sync_q    = {sync_q[0], direct};
      next_taps      = {taps[0], sync_q[SYNC_STAGES-1]};
      // All three samples must agree: five ticks of delay from the lookup output to the filter output.
      if (taps == 2'h3 && sync_q[SYNC_STAGES-1]) begin
        next_filt = 1'b1;
      end else if (taps == 2'h0 && !sync_q[SYNC_STAGES-1]) begin
        next_filt = 1'b0;
      end
      next_edge_prev = staged;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_line_prev <= 1'b0;
      sync_q        <= '0;
      taps          <= '0;
      filt          <= 1'b0;
      edge_prev     <= 1'b0;
    end else begin
      clk_line_prev <= next_clk_line_prev;
      sync_q        <= next_sync_q;
      taps          <= next_taps;
      filt          <= next_filt;
      edge_prev     <= next_edge_prev;
    end
  end

  // ==========================================================================
  // Output selection; reserved filter code behaves as the plain path.
  always_comb begin
    case (ctrl.output_filter_select)
      FILT_SYNC:  staged = sync_q[SYNC_STAGES-1];
      FILT_MAJOR: staged = filt;
      default:    staged = direct;
    endcase
    // Pulse lasts one tick; falling edges need an inverted truth word.
    result = active && (ctrl.rising_pulse_enable ? (staged && !edge_prev) : staged);
  end

  // ==========================================================================
  // Checks
  property p_filter_delay;
    @(posedge clk_sys) disable iff (!rst_n)
      (active && direct && ctrl.output_filter_select == FILT_MAJOR && !ctrl.cell_clock_source
       && !ctrl.rising_pulse_enable) [*5] |=> result;
  endproperty
  a_filter_delay: assert property (p_filter_delay) else $error("Filtered output late.");

  property p_sync_delay;
    @(posedge clk_sys) disable iff (!rst_n)
      (active && !direct && ctrl.output_filter_select == FILT_SYNC && !ctrl.cell_clock_source
       && !ctrl.rising_pulse_enable) [*2] |=> !result;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("Synchronized output late.");

  property p_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      !active |=> (sync_q == '0 && taps == '0 && !filt && !edge_prev);
  endproperty
  a_clear: assert property (p_clear) else $error("Cell state not cleared.");

  property p_pulse;
    @(posedge clk_sys) disable iff (!rst_n)
      (active && ctrl.rising_pulse_enable && !ctrl.cell_clock_source && result)
      ##1 (active && ctrl.rising_pulse_enable && !ctrl.cell_clock_source) |-> !result;
  endproperty
  a_pulse: assert property (p_pulse) else $error("Pulse longer than one cycle.");

endmodule

// ===== rtl/custom_glue_logic.sv
/*
  Custom glue logic pair: control state with enable protection, input source selection,
  two look-up cells and the shared sequential element.
  Assumes control writes arrive as one-cycle strobes on clk_sys; pins and event lines are
  asynchronous and are synchronized here; peripheral signals are already on clk_sys.
*/
`timescale 1ns/100ps
module custom_glue_logic (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire glue_pkg::reg_write_t reg_wr,
  input  wire logic                 comparator_out,
  input  wire logic [2:0]           timer_wave,
  input  wire logic [1:0]           sub_block_in,
  input  wire logic [1:0][2:0]      pin_in,
  input  wire logic                 event_line_zero,
  input  wire logic                 event_line_one,
  output logic [1:0]                cell_out,
  output logic [1:0]                pin_out,
  output logic [1:0]                pin_oe,
  output glue_pkg::readback_t       readback
);
  import glue_pkg::*;

  logic                  global_enable;
  logic                  next_global_enable;
  logic [3:0]            pair_function_select;
  logic [3:0]            next_pair_function_select;
  cell_control_a_t [1:0] control_a;
  cell_control_a_t [1:0] next_control_a;
  cell_control_b_t [1:0] control_b;
  cell_control_b_t [1:0] next_control_b;
  logic [1:0][3:0]       control_c;
  logic [1:0][3:0]       next_control_c;
  logic [1:0][7:0]       truth;
  logic [1:0][7:0]       next_truth;
  logic [7:0]            async_raw;
  logic [7:0]            meta_q;
  logic [7:0]            sync_q;
  logic [1:0]            active;
  logic [1:0][2:0]       lines;
  logic [1:0]            tick;
  logic [1:0]            direct;
  logic [1:0]            result;
  logic                  seq_q;
  logic                  next_seq_q;
  logic                  clear_hold;
  logic                  next_clear_hold;
  logic                  seq_clear;
  logic                  seq_out;
  logic                  seq_on;

  // ==========================================================================
  // Source picker, used for all six input lines.
  function automatic logic pick_source(input logic [3:0] sel, input logic is_line2, input logic fb,
                                       input logic link, input logic ev0, input logic ev1,
                                       input logic pin, input logic [2:0] tw, input logic sub);
    logic v;
    v = 1'b0;
    case (sel)
      SRC_FEEDBACK:   v = is_line2 ? 1'b0 : fb;
      SRC_LINK:       v = link;
      SRC_EVENT_LINE_ZERO:     v = ev0;
      SRC_EVENT_LINE_ONE:     v = ev1;
      SRC_PIN:        v = pin;
      SRC_COMPARATOR: v = comparator_out;
      SRC_TIMER0:     v = tw[0];
      SRC_TIMER1:     v = tw[1];
      SRC_TIMER2:     v = tw[2];
      SRC_SUBBLOCK:   v = sub;
      default:        v = 1'b0;
    endcase
    return v;
  endfunction

  // ==========================================================================
  // Control state. Protected fields move only while their cell is off; the enable bit
  // itself always takes the write, so a set-enable write carries the new setup in.
  always_comb begin
    next_global_enable        = global_enable;
    next_pair_function_select = pair_function_select;
    next_control_a            = control_a;
    next_control_b            = control_b;
    next_control_c            = control_c;
    next_truth                = truth;
    if (reg_wr.global_enable_wr) begin
      next_global_enable = reg_wr.wdata[0];
    end
    if (reg_wr.pair_function_wr && !control_a[0].enable) begin
      next_pair_function_select = reg_wr.wdata[3:0];
    end
    for (int n = 0; n < NUM_CELLS; n++) begin
      if (reg_wr.control_a_wr[n]) begin
        next_control_a[n].enable = reg_wr.wdata[0];
        // A write that clears enable on a running cell leaves the setup alone.
        if (!control_a[n].enable) begin
          next_control_a[n]          = cell_control_a_t'(reg_wr.wdata);
          next_control_a[n].reserved = 2'h0;
        end
      end
      if (reg_wr.control_b_wr[n] && !control_a[n].enable) begin
        next_control_b[n] = cell_control_b_t'(reg_wr.wdata);
      end
      if (reg_wr.control_c_wr[n] && !control_a[n].enable) begin
        next_control_c[n] = reg_wr.wdata[3:0];
      end
      if (reg_wr.truth_wr[n]) begin
        next_truth[n] = reg_wr.wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      global_enable        <= 1'b0;
      pair_function_select <= PAIR_FN_RESET;
      control_a            <= {NUM_CELLS{CONTROL_A_RESET}};
      control_b            <= {NUM_CELLS{CONTROL_B_RESET}};
      control_c            <= {NUM_CELLS{CONTROL_C_RESET}};
      truth                <= {NUM_CELLS{TRUTH_RESET}};
    end else begin
      global_enable        <= next_global_enable;
      pair_function_select <= next_pair_function_select;
      control_a            <= next_control_a;
      control_b            <= next_control_b;
      control_c            <= next_control_c;
      truth                <= next_truth;
    end
  end

  assign readback = '{global_enable, pair_function_select, control_a, control_b, control_c, truth};

  // ==========================================================================
  // Pins and event lines cross in through two flip-flops before any use.
  assign async_raw = {event_line_one, event_line_zero, pin_in[1], pin_in[0]};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end else begin
      meta_q <= async_raw;
      sync_q <= meta_q;
    end
  end

  // ==========================================================================
  // Cells. The odd cell has no higher neighbour, so its link reads low.
  for (genvar n = 0; n < NUM_CELLS; n++) begin : g_cell
    logic link_in;
    assign link_in   = (n + 1 < NUM_CELLS) ? direct[(n + 1) % NUM_CELLS] : 1'b0;
    assign active[n] = global_enable && control_a[n].enable;
    // Feedback uses the registered element state so latch modes form no loop.
    assign lines[n][0] = pick_source(control_b[n].input_zero_source_select, 1'b0, seq_q, link_in,
                                     sync_q[6], sync_q[7], sync_q[3*n], timer_wave,
                                     sub_block_in[n]);
    assign lines[n][1] = pick_source(control_b[n].input_one_source_select, 1'b0, seq_q, link_in,
                                     sync_q[6], sync_q[7], sync_q[3*n+1], timer_wave,
                                     sub_block_in[n]);
    assign lines[n][2] = pick_source(control_c[n], 1'b1, seq_q, link_in,
                                     sync_q[6], sync_q[7], sync_q[3*n+2], timer_wave,
                                     sub_block_in[n]);
    lookup_cell lookup_cell_inst (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .active  (active[n]),
      .ctrl    (control_a[n]),
      .truth   (truth[n]),
      .lines   (lines[n]),
      .tick    (tick[n]),
      .direct  (direct[n]),
      .result  (result[n])
    );
  end

  // ==========================================================================
  // Sequential element. Clear acts at once on disable and is stretched one cycle after
  // re-enable, so the element never starts from a half-written state.
  assign seq_clear = !active[0] || clear_hold;
  assign seq_on    = pair_function_select != SEQ_OFF;

  always_comb begin
    next_clear_hold = !active[0];
    next_seq_q      = seq_q;
    if (seq_clear) begin
      next_seq_q = 1'b0;
    end else if (tick[0]) begin
      case (pair_function_select)
        SEQ_DFF:   next_seq_q = result[1] ? result[0] : seq_q;
        SEQ_JK:    next_seq_q = (result[0] && !seq_q) || (!result[1] && seq_q);
        SEQ_LATCH: next_seq_q = result[1] ? result[0] : seq_q;
        SEQ_RS:    next_seq_q = result[0] || (!result[1] && seq_q);
        default:   next_seq_q = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clear_hold <= 1'b1;
      seq_q      <= 1'b0;
    end else begin
      clear_hold <= next_clear_hold;
      seq_q      <= next_seq_q;
    end
  end

  // Latches are transparent at once; flip-flops show only the stored state.
  always_comb begin
    case (pair_function_select)
      SEQ_LATCH: seq_out = !seq_clear && (result[1] ? result[0] : seq_q);
      // Both high is forbidden; set is given priority here.
      SEQ_RS:    seq_out = !seq_clear && (result[0] || (!result[1] && seq_q));
      SEQ_DFF:   seq_out = seq_q;
      SEQ_JK:    seq_out = seq_q;
      default:   seq_out = 1'b0;
    endcase
  end

  // ==========================================================================
  // Outputs. The even cell carries the element output while a function is chosen.
  always_comb begin
    cell_out[0] = active[0] && (seq_on ? seq_out : result[0]);
    cell_out[1] = active[1] && result[1];
    pin_out     = cell_out;
    pin_oe      = {active[1] && control_a[1].output_enable, active[0] && control_a[0].output_enable};
  end

  // ==========================================================================
  // Checks
  property p_pair_protect;
    @(posedge clk_sys) disable iff (!rst_n)
      (reg_wr.pair_function_wr && control_a[0].enable) |=> $stable(pair_function_select);
  endproperty
  a_pair_protect: assert property (p_pair_protect) else $error("Pair function changed while on.");

  property p_ctrl_protect;
    @(posedge clk_sys) disable iff (!rst_n)
      (reg_wr.control_b_wr[0] && control_a[0].enable) |=> $stable(control_b[0]);
  endproperty
  a_ctrl_protect: assert property (p_ctrl_protect) else $error("Protected field changed.");

  property p_enable_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      (reg_wr.control_a_wr[0] && control_a[0].enable && !reg_wr.wdata[0])
      |=> (!control_a[0].enable && control_a[0][7:1] == $past(control_a[0][7:1]));
  endproperty
  a_enable_clear: assert property (p_enable_clear) else $error("Clearing write moved setup.");

  property p_enable_set;
    @(posedge clk_sys) disable iff (!rst_n)
      (reg_wr.control_a_wr[0] && !control_a[0].enable && reg_wr.wdata[0])
      |=> (control_a[0] == ($past(reg_wr.wdata) & 8'hF9));
  endproperty
  a_enable_set: assert property (p_enable_set) else $error("Enabling write lost setup.");

  property p_global;
    @(posedge clk_sys) disable iff (!rst_n)
      !global_enable |-> (cell_out == 2'h0 && pin_oe == 2'h0);
  endproperty
  a_global: assert property (p_global) else $error("Output active while block off.");

  property p_seq_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(active[0]) |-> ##1 (seq_q == 1'b0);
  endproperty
  a_seq_clear: assert property (p_seq_clear) else $error("Reset not held one cycle.");

  property p_jk_toggle;
    @(posedge clk_sys) disable iff (!rst_n)
      (pair_function_select == SEQ_JK && !seq_clear && tick[0] && result[0] && result[1])
      |=> (seq_q != $past(seq_q));
  endproperty
  a_jk_toggle: assert property (p_jk_toggle) else $error("JK did not toggle.");

  property p_dff_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      (pair_function_select == SEQ_DFF && !seq_clear && !result[1]) |=> $stable(seq_q);
  endproperty
  a_dff_hold: assert property (p_dff_hold) else $error("Flip-flop moved with gate low.");

  property p_feedback;
    @(posedge clk_sys) disable iff (!rst_n)
      (control_b[0].input_zero_source_select == SRC_FEEDBACK) |-> (lines[0][0] == seq_q);
  endproperty
  a_feedback: assert property (p_feedback) else $error("Feedback line wrong.");

endmodule

// ===== testbench/glue_partner.sv
/* Far-side model: peripherals, pins and event lines of the glue pair.
   Assumes the bench sets one level pattern just after a clock edge. */
`timescale 1ns/100ps
module glue_partner (
  input  wire logic [3:0]      pattern,
  output logic                 comparator_out,
  output logic [2:0]           timer_wave,
  output logic [1:0]           sub_block_in,
  output logic [1:0][2:0]      pin_in,
  output logic                 event_line_zero,
  output logic                 event_line_one
);
  // ==========
  // Sources
  // Every source follows the pattern, so any select of a partner source sees a live level.
  always_comb begin
    comparator_out  = pattern[0];
    timer_wave      = pattern[3:1];
    sub_block_in    = pattern[1:0];
    pin_in          = {2{pattern[2:0]}};
    event_line_zero = pattern[0]; // Routed before a cell picks it.
    event_line_one  = ~pattern[0];
  end
endmodule

// ===== testbench/tb_custom_glue_logic.sv
/* Bench of the glue pair: lookup, enable protection and the flip-flop mode.
   Assumes the partner model drives every source from one pattern. */
`timescale 1ns/100ps
module tb_custom_glue_logic;
  import glue_pkg::*;
  localparam logic [9:0] G = 10'h200, P = 10'h100, A0 = 10'h040, A1 = 10'h080;
  localparam logic [9:0] B0 = 10'h010, C0 = 10'h004, T0 = 10'h001, T1 = 10'h002;
  localparam logic [9:0] B1 = 10'h020, C1 = 10'h008;
  localparam logic [7:0] TT = 8'hB4;
  logic            clk_sys = 1'b0;
  logic            rst_n = 1'b0;
  reg_write_t      reg_wr = '0;
  logic [3:0]      pattern = 4'h0;
  logic            cmp, ev0, ev1;
  logic [2:0]      tw;
  logic [1:0]      sub, cell_out, pin_out, pin_oe;
  logic [1:0][2:0] pins;
  readback_t       readback;
  int              failures = 0;
  int              n_tests = 0;
  always #50 clk_sys = ~clk_sys;
  glue_partner glue_partner_inst (.pattern(pattern), .comparator_out(cmp), .timer_wave(tw),
    .sub_block_in(sub), .pin_in(pins), .event_line_zero(ev0), .event_line_one(ev1));
  custom_glue_logic custom_glue_logic_inst (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr),
    .comparator_out(cmp), .timer_wave(tw), .sub_block_in(sub), .pin_in(pins), .event_line_zero(ev0),
    .event_line_one(ev1), .cell_out(cell_out), .pin_out(pin_out), .pin_oe(pin_oe), .readback(readback));
  // ==========
  // Helpers
  // Four-state compare, so an unknown never passes.
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One strobed write and one idle cycle, so back-to-back calls never drive the strobes twice at once.
  task automatic wr(input logic [9:0] s, input logic [7:0] d);
    reg_wr = {s, d};
    step(1);
    reg_wr = '0;
    step(1);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask
  // ==========
  // Scenarios
  task automatic test_lookup();
    wr(B0, 8'h76);
    wr(C0, 8'h08);
    wr(T0, TT);
    wr(G, 8'h01);
    wr(A0, 8'h09);
    for (int i = 0; i < 8; i++) begin
      pattern = 4'(i);
      step(1);
      check("lookup", TT[i], cell_out[0]);
    end
    check("pin_oe", 2'b01, pin_oe);
    check("pin_out", 2'b01, pin_out);
  endtask
  // Protected writes while the cell runs must leave setup untouched.
  task automatic test_protect();
    wr(B0, 8'h00);
    check("ctrl_b0", 8'h76, readback.control_b[0]);
    wr(P, 8'h02);
    check("pair_fn", 4'h0, readback.pair_function_select);
    wr(G, 8'h00);
    check("global_off", 2'b00, cell_out);
    wr(A0, 8'h00);
    check("ctrl_a0", 8'h08, readback.control_a[0]);
  endtask
  // Gate from cell one: high loads the even cell, low holds.
  task automatic test_dff();
    wr(P, 8'h01);
    check("pair_fn", 4'h1, readback.pair_function_select);
    wr(T1, 8'hFF);
    wr(G, 8'h01);
    wr(A1, 8'h01);
    pattern = 4'h7;
    wr(A0, 8'h01);
    step(3);
    check("dff_set", 1'b1, cell_out[0]);
    pattern = 4'h0;
    step(2);
    check("dff_clear", 1'b0, cell_out[0]);
    wr(A1, 8'h00);
    pattern = 4'h7;
    step(3);
    check("dff_hold", 1'b0, cell_out[0]);
  endtask
  // JK, latch and RS modes: cell zero drives J, D or S, cell one drives K, gate or R.
  task automatic test_seq();
    wr(A0, 8'h00);
    wr(P, 8'h02);
    wr(A0, 8'h01);
    step(2);
    check("jk_set", 1'b1, cell_out[0]);
    pattern = 4'h0;
    step(2);
    check("jk_hold", 1'b1, cell_out[0]);
    wr(A1, 8'h01);
    check("jk_clear", 1'b0, cell_out[0]);
    pattern = 4'h7;
    step(1);
    check("jk_toggle", 1'b1, cell_out[0]);
    step(1);
    check("jk_toggle", 1'b0, cell_out[0]);
    wr(A0, 8'h00);
    wr(P, 8'h03);
    wr(A0, 8'h01);
    check("latch_follow", 1'b1, cell_out[0]);
    wr(A1, 8'h00);
    pattern = 4'h0;
    step(1);
    check("latch_hold", 1'b1, cell_out[0]);
    wr(A1, 8'h01);
    check("latch_follow", 1'b0, cell_out[0]);
    wr(A0, 8'h00);
    wr(P, 8'h04);
    wr(A1, 8'h00);
    wr(A0, 8'h01);
    pattern = 4'h7;
    step(1);
    check("rs_set", 1'b1, cell_out[0]);
    pattern = 4'h0;
    step(1);
    check("rs_hold", 1'b1, cell_out[0]);
    wr(A1, 8'h01);
    check("rs_clear", 1'b0, cell_out[0]);
  endtask
  // Cell one follows the comparator through the majority filter with the pulse detector on.
  task automatic test_pulse();
    wr(A1, 8'h00);
    wr(B1, 8'h06);
    wr(T1, 8'hAA);
    wr(A1, 8'hA1);
    pattern = 4'h1;
    step(1);
    check("filter_early", 1'b0, cell_out[1]);
    step(4);
    check("pulse", 1'b1, cell_out[1]);
    step(1);
    check("pulse_end", 1'b0, cell_out[1]);
    wr(A1, 8'h00);
    check("cell_off", 1'b0, cell_out[1]);
  endtask
  // Line two clocks the cell, so it must read low in the lookup.
  task automatic test_clock_mask();
    wr(C1, 8'h06);
    wr(T1, 8'h0F);
    wr(A1, 8'h41);
    check("line2_masked", 1'b1, cell_out[1]);
  endtask
  // Event line one passes two input flip-flops and then the output synchronizer.
  task automatic test_events();
    wr(A1, 8'h00);
    wr(B1, 8'h04);
    wr(T1, 8'hAA);
    wr(A1, 8'h11);
    pattern = 4'h0;
    step(3);
    check("event_early", 1'b0, cell_out[1]);
    step(1);
    check("event_sync", 1'b1, cell_out[1]);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    #10 rst_n = 1'b1;
    check("reset", 64'h0, readback);
    test_lookup();
    test_protect();
    test_dff();
    test_seq();
    test_pulse();
    test_clock_mask();
    test_events();
    complete_run();
  end
  // A hang counts as a mismatch.
  initial begin
    #200000;
    failures++;
    complete_run();
  end
endmodule
